// ### seq_ctrl_pkg.sv
// constants shared by the microprogram sequence controller
// assumes a single 40 MHz micro-cycle clock and synchronous control-store proms
package seq_ctrl_pkg;
    localparam int ADDR_W = 8;
    localparam int RPT_W = 4;
    localparam int COND_N = 4;
    localparam int SEL_W = 3;
    localparam int STAGE_W = 2;
    localparam logic [RPT_W-1:0] RPT_DONE = 4'hF;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;
    localparam logic [SEL_W-1:0] SEL_RPT = 3'h0;
    localparam logic [SEL_W-1:0] SEL_TRUE = 3'h1;
    localparam logic [SEL_W-1:0] SEL_EXT0 = 3'h4;
    // next-address operation encoded in the pipelined word
    typedef enum logic [2:0] {
        OP_CONT = 3'b000,
        OP_JUMP = 3'b001,
        OP_CALL = 3'b010,
        OP_RET = 3'b011,
        OP_DECODE = 3'b100,
        OP_REPEAT = 3'b101,
        OP_FETCH = 3'b110
    } next_op_t;
endpackage

// ### seq_ctrl.sv
// microprogram sequence controller: next-address logic, save register,
// repeat counter, condition mux and multiple command decode
// assumes the proms return the pipelined word for address next_addr in one cycle
//
// How it works
// RULE_01 - a call saves the current address plus one in the save register.
// RULE_02 - multiple decode reuses the command register, the first pass giving the first entry.
// RULE_03 - finishing a sub-sequence advances the decode stage to decode the command again.
// RULE_04 - fast outputs are registered at the cycle start, slow ones decoded from the address; the code has no slow outputs.
// RULE_05 - a condition mux picks repeat status or an external signal to steer the next address.
// RULE_06 - external conditions are captured at the clock and held for the whole micro-cycle.
// RULE_07 - interrupt and dma requests are only taken at instruction boundaries; the code has one request input, irq_req, and no dma request.
// RULE_08 - repeat status low selects the repeat address, high selects the incremented address.
// RULE_09 - the repeat counter steps only in cycles where it steers the next-address mux.
// RULE_10 - the repeat counter is four bits and terminates at all ones.
// RULE_11 - a subroutine end takes its next address from the save register.
module seq_ctrl
    import seq_ctrl_pkg::*;
#(
    parameter int FAST_W = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // pipelined word from the control-store proms
    input wire logic [2:0] op_code,
    input wire logic [ADDR_W-1:0] branch_addr,
    input wire logic [SEL_W-1:0] cond_sel,
    input wire logic cond_pol,
    input wire logic rpt_load,
    input wire logic [RPT_W-1:0] rpt_value,
    input wire logic [FAST_W-1:0] fast_word,
    input wire logic end_of_instr,
    // decode proms: entry address per decode stage
    input wire logic [ADDR_W-1:0] decode_addr,
    // command register and service requests
    input wire logic [ADDR_W-1:0] command,
    input wire logic cmd_load,
    input wire logic irq_req,
    input wire logic [ADDR_W-1:0] irq_addr,
    // external condition signals
    input wire logic [COND_N-1:0] cond_in,
    // outputs
    output logic [ADDR_W-1:0] next_addr,
    output logic [FAST_W-1:0] fast_out,
    output logic [ADDR_W-1:0] cmd_reg,
    output logic [STAGE_W-1:0] decode_stage,
    output logic [RPT_W-1:0] rpt_count,
    output logic rpt_done,
    output logic irq_ack
);
    logic [COND_N-1:0] cond_buf;
    logic [ADDR_W-1:0] save_addr;
    logic [ADDR_W-1:0] addr_plus1;
    logic cond_raw;
    logic cond_true;
    logic [ADDR_W-1:0] next_next_addr;
    next_op_t op;

    assign op = next_op_t'(op_code);
    assign addr_plus1 = ADDR_W'(next_addr + 1'b1);
    assign rpt_done = (rpt_count == RPT_DONE); // RULE_10

    // condition mux: repeat status, constant true or a buffered signal
    function automatic logic pick_cond(input logic [SEL_W-1:0] sel,
                                       input logic [COND_N-1:0] buf_in,
                                       input logic done);
        logic r;
        r = 1'b0;
        if (sel == SEL_RPT) begin
            r = done;
        end else if (sel == SEL_TRUE) begin
            r = 1'b1;
        end else if (sel >= SEL_EXT0) begin
            r = buf_in[2'(sel - SEL_EXT0)];
        end
        return r;
    endfunction

    assign cond_raw = pick_cond(cond_sel, cond_buf, rpt_done); // RULE_05
    assign cond_true = cond_raw ^ cond_pol;

    // next-address selection
    always_comb begin
        next_next_addr = addr_plus1;
        case (op)
            OP_CONT: next_next_addr = addr_plus1;
            OP_JUMP: next_next_addr = cond_true ? branch_addr : addr_plus1; // RULE_05
            OP_CALL: next_next_addr = cond_true ? branch_addr : addr_plus1;
            OP_RET: next_next_addr = save_addr; // RULE_11
            // loop back while not done: the mux follows the counter status
            OP_REPEAT: next_next_addr = rpt_done ? addr_plus1 : branch_addr; // RULE_08
            OP_DECODE: next_next_addr = decode_addr; // RULE_02
            OP_FETCH: next_next_addr = decode_addr;
            default: next_next_addr = addr_plus1;
        endcase
        // interrupts only between instructions so latency stays bounded
        if (end_of_instr && irq_req) begin
            next_next_addr = irq_addr; // RULE_07
        end
    end

    // external conditions buffered so they hold for the micro-cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cond_buf <= '0;
        end else begin
            cond_buf <= cond_in; // RULE_06
        end
    end

    // address register sits after the incrementer for early availability
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            next_addr <= ADDR_RESET;
            fast_out <= '0;
        end else begin
            next_addr <= next_next_addr; // RULE_04
            fast_out <= fast_word; // RULE_04
        end
    end

    // save register: return point of a taken call
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            save_addr <= ADDR_RESET;
        end else if (op == OP_CALL && cond_true) begin
            save_addr <= addr_plus1; // RULE_01
        end
    end

    // repeat counter: loaded from the word, stepped only when it steers
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rpt_count <= RPT_DONE;
        end else if (rpt_load) begin
            rpt_count <= rpt_value;
        end else if (op == OP_REPEAT && !rpt_done) begin
            rpt_count <= RPT_W'(rpt_count + 1'b1); // RULE_09
        end
    end

    // command register and decode stage; fetch restarts at stage zero
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cmd_reg <= '0;
            decode_stage <= '0;
        end else begin
            if (cmd_load) begin
                cmd_reg <= command;
            end
            if (op == OP_FETCH || cmd_load) begin
                decode_stage <= '0;
            end else if (op == OP_DECODE) begin
                decode_stage <= STAGE_W'(decode_stage + 1'b1); // RULE_03
            end
        end
    end

    // acknowledge pulse for a serviced request
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            irq_ack <= 1'b0;
        end else begin
            irq_ack <= end_of_instr && irq_req; // RULE_07
        end
    end

    // checks
    sequence s_call_taken;
        op == OP_CALL && cond_true;
    endsequence

    // one pass of a group loop that is not yet finished and not reloaded
    sequence s_loop_step;
        op == OP_REPEAT && !rpt_done && !rpt_load;
    endsequence

    a_call_saves: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_01
        s_call_taken ##1 1'b1 |-> save_addr == $past(addr_plus1))
        else $error("call did not save return address");
    a_ret_uses_save: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_11
        (op == OP_RET && !(end_of_instr && irq_req)) |=> next_addr == $past(save_addr))
        else $error("return did not use save register");
    a_decode_entry: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_02
        (op == OP_DECODE && !(end_of_instr && irq_req)) |=> next_addr == $past(decode_addr))
        else $error("decode entry address wrong");
    a_decode_stage_step: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_03
        (op == OP_DECODE && !cmd_load) |=> decode_stage == $past(decode_stage) + 2'h1)
        else $error("decode stage did not advance");
    a_fast_regd: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_04
        1'b1 |=> fast_out == $past(fast_word))
        else $error("fast outputs not registered");
    a_jump_cond: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_05
        (op == OP_JUMP && !cond_true && !(end_of_instr && irq_req))
        |=> next_addr == $past(addr_plus1))
        else $error("jump taken on false condition");
    a_cond_buffer: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_06
        ##1 cond_buf == $past(cond_in))
        else $error("condition buffer not captured");
    a_irq_boundary: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_07
        irq_ack |-> $past(end_of_instr && irq_req))
        else $error("request serviced mid-instruction");
    a_irq_vector: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_07
        (end_of_instr && irq_req) |=> next_addr == $past(irq_addr))
        else $error("boundary request did not redirect the address");
    a_repeat_loop: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_08
        (op == OP_REPEAT && !rpt_done && !(end_of_instr && irq_req))
        |=> next_addr == $past(branch_addr))
        else $error("repeat did not loop back");
    a_rpt_hold: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_09
        (op != OP_REPEAT && !rpt_load) |=> $stable(rpt_count))
        else $error("repeat counter moved outside loop");
    a_rpt_terminal: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_10
        (rpt_done && op == OP_REPEAT && !rpt_load) |=> rpt_count == 4'hF)
        else $error("counter left terminal state");
    // a finished loop must fall through to the next word
    a_repeat_exit: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_08
        (op == OP_REPEAT && rpt_done && !(end_of_instr && irq_req))
        |=> next_addr == $past(addr_plus1))
        else $error("finished repeat did not fall through");
    a_rpt_step: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_09
        s_loop_step |=> rpt_count == $past(rpt_count) + 4'h1)
        else $error("repeat counter did not step once per pass");
    a_fetch_restart: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE_02
        (op == OP_FETCH && !cmd_load) |=> decode_stage == '0)
        else $error("fetch did not restart the decode stage");
endmodule

// ### decode_prom.sv
// decode prom model: entry address per command and decode stage
// assumes cmd_reg and decode_stage come registered from the sequencer
module decode_prom
    import seq_ctrl_pkg::*;
(
    // command and stage from the sequencer
    input wire logic [ADDR_W-1:0] cmd_reg,
    input wire logic [STAGE_W-1:0] decode_stage,
    // entry address back to the sequencer
    output logic [ADDR_W-1:0] decode_addr
);
    timeunit 1ns;
    timeprecision 100ps;
    // low command bits pick the routine, the stage picks each sub-sequence
    assign decode_addr = {cmd_reg[5:0], decode_stage};
endmodule

// ### test_seq_ctrl.sv
// self-checking bench for the sequence controller
// assumes the decode prom model answers combinationally
module test_seq_ctrl;
    timeunit 1ns;
    timeprecision 100ps;
    import seq_ctrl_pkg::*;
    logic sys_clk = 0, rst_b = 0, cond_pol = 0, rpt_load = 0, cmd_load = 0;
    logic irq_req = 0, end_of_instr = 0, rpt_done, irq_ack;
    logic [2:0] op_code = 0, cond_sel = 0;
    logic [7:0] branch_addr = 0, command = 0, irq_addr = 0, fast_word = 0;
    logic [7:0] decode_addr, next_addr, fast_out, cmd_reg, a;
    logic [3:0] rpt_value = 0, cond_in = 0, rpt_count;
    logic [1:0] decode_stage;
    logic [16:0] notes[$], note;
    int errors = 0, check_count = 0, cycles = 0;
    // strobes for the next step only: rpt_load, cmd_load, irq_req, end_of_instr;
    // staged so every pin changes once per falling edge
    logic [3:0] next_strobe = 4'h0;
    seq_ctrl #(.FAST_W(8)) uut (.sys_clk(sys_clk), .rst_b(rst_b), .op_code(op_code),
        .branch_addr(branch_addr), .cond_sel(cond_sel), .cond_pol(cond_pol),
        .rpt_load(rpt_load), .rpt_value(rpt_value), .fast_word(fast_word),
        .end_of_instr(end_of_instr), .decode_addr(decode_addr), .command(command),
        .cmd_load(cmd_load), .irq_req(irq_req), .irq_addr(irq_addr), .cond_in(cond_in),
        .next_addr(next_addr), .fast_out(fast_out), .cmd_reg(cmd_reg),
        .decode_stage(decode_stage), .rpt_count(rpt_count), .rpt_done(rpt_done),
        .irq_ack(irq_ack));
    decode_prom prom (.cmd_reg(cmd_reg), .decode_stage(decode_stage),
        .decode_addr(decode_addr));
    initial forever #12.5 sys_clk = ~sys_clk;
    task automatic final_report;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // drive one micro-word at the falling edge and note its expected result
    task automatic step(input logic [2:0] op, input logic [7:0] br, input logic [2:0] sel,
                        input logic pol, input logic [7:0] ea, input logic ek);
        {rpt_load, cmd_load, irq_req, end_of_instr} = next_strobe;
        next_strobe = 4'h0;
        op_code = op;
        branch_addr = br;
        cond_sel = sel;
        cond_pol = pol;
        fast_word = 8'($urandom);
        cond_in = 4'($urandom);
        notes.push_back({ea, fast_word, ek});
        a = ea;
        @(negedge sys_clk);
    endtask
    // a hang counts as a mismatch
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 600) begin
            errors++;
            final_report;
        end
    end
    // take the oldest note once the edge's updates have landed
    always @(posedge sys_clk) begin
        #2;
        if (notes.size() > 0) begin
            note = notes.pop_front();
            check({next_addr, fast_out, irq_ack}, note);
        end
    end
    initial begin
        void'($urandom(32'hC568));
        repeat (8) @(negedge sys_clk);
        rst_b = 1;
        a = ADDR_RESET;
        check({next_addr, fast_out, irq_ack}, 17'h0);
        step(OP_CONT, 8'h00, SEL_TRUE, 0, a + 8'h01, 0);
        // the unused op code behaves as continue
        step(3'h7, 8'h00, SEL_TRUE, 0, a + 8'h01, 0);
        step(OP_JUMP, 8'h20, SEL_TRUE, 0, 8'h20, 0);
        step(OP_JUMP, 8'h70, SEL_TRUE, 1, a + 8'h01, 0);
        // call, refused call, return past both
        step(OP_CALL, 8'h40, SEL_TRUE, 0, 8'h40, 0);
        step(OP_CALL, 8'h50, SEL_TRUE, 1, a + 8'h01, 0);
        step(OP_RET, 8'h00, SEL_TRUE, 0, 8'h22, 0);
        // buffered external conditions, a dead select, counter status
        for (int i = 0; i < 4; i++) begin
            step(OP_JUMP, 8'h60, 3'(SEL_EXT0 + i), 0, cond_in[i] ? 8'h60 : a + 8'h01, 0);
        end
        step(OP_JUMP, 8'h60, 3'h2, 0, a + 8'h01, 0);
        step(OP_JUMP, 8'h30, SEL_RPT, 0, 8'h30, 0);
        // counter only steps on repeat cycles
        next_strobe = 4'h8;
        rpt_value = 4'hD;
        step(OP_CONT, 8'h00, SEL_TRUE, 0, a + 8'h01, 0);
        step(OP_CONT, 8'h00, SEL_TRUE, 0, a + 8'h01, 0);
        check({13'h0, rpt_count}, 17'hD);
        check({16'h0, rpt_done}, 17'h0);
        step(OP_REPEAT, a, SEL_RPT, 0, a, 0);
        step(OP_REPEAT, a, SEL_RPT, 0, a, 0);
        step(OP_REPEAT, a, SEL_RPT, 0, a + 8'h01, 0);
        check({13'h0, rpt_count}, {13'h0, RPT_DONE});
        check({16'h0, rpt_done}, 17'h1);
        // multiple decode of one command
        command = 8'($urandom);
        next_strobe = 4'h4;
        step(OP_CONT, 8'h00, SEL_TRUE, 0, a + 8'h01, 0);
        check({9'h0, cmd_reg}, {9'h0, command});
        check({15'h0, decode_stage}, 17'h0);
        step(OP_FETCH, 8'h00, SEL_TRUE, 0, {command[5:0], 2'h0}, 0);
        for (int s = 0; s < 3; s++) begin
            step(OP_DECODE, 8'h00, SEL_TRUE, 0, {command[5:0], 2'(s)}, 0);
        end
        check({15'h0, decode_stage}, 17'h3);
        // service request ignored mid-instruction, taken at a boundary
        next_strobe = 4'h2;
        irq_addr = 8'hA5;
        step(OP_CONT, 8'h00, SEL_TRUE, 0, a + 8'h01, 0);
        next_strobe = 4'h3;
        step(OP_CONT, 8'h00, SEL_TRUE, 0, 8'hA5, 1);
        step(OP_CONT, 8'h00, SEL_TRUE, 0, a + 8'h01, 0);
        repeat (2) @(negedge sys_clk);
        final_report;
    end
endmodule
